// *** logic/fel_pkg.sv ***
package fel_pkg;

    // Upper memory tables that hold this block's registers
    localparam logic [7:0] TBL_ENABLE_HOME = 8'h01;
    localparam logic [7:0] TBL_ENABLE_ALT  = 8'h05;
    localparam logic [7:0] TBL_CONTROL     = 8'h02;

    // Byte offsets inside a table
    localparam logic [7:0] ADDR_RSVD_FA    = 8'hFA;
    localparam logic [7:0] ADDR_LOS_EN     = 8'hFB;
    localparam logic [7:0] ADDR_WARN_EN    = 8'hFC;
    localparam logic [7:0] ADDR_RSVD_ROW   = 8'hFD;
    localparam logic [7:0] ADDR_MODE       = 8'h80;
    localparam logic [7:0] ADDR_THERMAL_LUT_INDEX     = 8'h81;
    localparam logic [7:0] ADDR_RSVD2_LO   = 8'h82;
    localparam logic [7:0] ADDR_RSVD2_HI   = 8'h85;

    // Register slots: two receiver copies of the loss enables, then shared ones
    localparam int REG_LOS1 = 0;
    localparam int REG_LOS2 = 1;
    localparam int REG_WARN = 2;
    localparam int REG_MODE = 3;
    localparam int REG_TIDX = 4;
    localparam int NUM_REGS = 5;

    localparam logic [7:0] RST_VAL [NUM_REGS] = '{8'h00, 8'h00, 8'h00, 8'h7F, 8'h00};
    localparam logic [7:0] WR_MASK [NUM_REGS] = '{8'hC0, 8'hC0, 8'hF0, 8'hCC, 8'hFF};
    localparam logic [7:0] RSVD_READ_VAL = 8'h00;

    // Field positions
    localparam int BIT_SIGNAL_LOSS_HIGH_ALARM     = 7;
    localparam int BIT_SIGNAL_LOSS_LOW_ALARM     = 6;
    localparam int BIT_TEMPERATURE_ABOVE_WARNING    = 7;
    localparam int BIT_TEMPERATURE_BELOW_WARNING    = 6;
    localparam int BIT_SUPPLY_ABOVE_WARNING     = 5;
    localparam int BIT_SUPPLY_BELOW_WARNING     = 4;
    localparam int BIT_SEE_BLOCK  = 7;
    localparam int BIT_AUTO_INDEX = 3;
    localparam int CONV_AUTO_BIT [2] = '{2, 6};

    // Temperature index arithmetic; temperature is signed, 1/256 degree units
    localparam int TEMP_FRAC_BITS = 8;
    localparam int TEMP_OFFSET_C  = 40;
    localparam int TEMP_MAX_C     = 102;
    localparam int INDEX_STEP_C   = 2;
    localparam int INDEX_SHIFT    = TEMP_FRAC_BITS + $clog2(INDEX_STEP_C);
    localparam logic [7:0] INDEX_BASE = 8'h80;
    localparam logic [7:0] INDEX_MAX  = 8'hC7;
    localparam logic       LUT_ROW_FIXED = 1'b1;
    localparam logic [7:0] LUT8_BASE  = 8'hF8;
    localparam logic [7:0] LUT8_TOP   = 8'hFF;

    typedef enum {TGT_NONE, TGT_REG, TGT_RSVD} fel_target_e;

    typedef struct packed {
        fel_target_e kind;
        logic [2:0]  idx;
        logic        tbl2;
    } fel_decode_s;

endpackage : fel_pkg

// *** logic/fel_calc_if.sv ***
`timescale 1ns/100ps
interface fel_calc_if #(parameter int TEMP_W = 16);
    logic signed [TEMP_W-1:0] temp;
    logic                     done;
    logic        [7:0]        index;
    logic                     upd;

    modport calc (input temp, input done, output index, output upd);
    modport user (output temp, output done, input index, input upd);
endinterface : fel_calc_if

// *** logic/fel_thermal_lut_index_calc.sv ***
`timescale 1ns/100ps
module fel_thermal_lut_index_calc #(
    parameter int TEMP_W = 16
) (
    // Clock and reset
    input  wire logic core_clk_in,
    input  wire logic sys_rst_in,
    // Measurement in, index out
    fel_calc_if.calc  calc_if
);
    localparam logic signed [TEMP_W:0] OFFSET_RAW =
        (TEMP_W+1)'(fel_pkg::TEMP_OFFSET_C <<< fel_pkg::TEMP_FRAC_BITS);
    localparam logic signed [TEMP_W:0] HIGH_RAW =
        (TEMP_W+1)'(fel_pkg::TEMP_MAX_C <<< fel_pkg::TEMP_FRAC_BITS);

    if (TEMP_W < 16) begin : g_bad_width
        $error("fel_thermal_lut_index_calc: TEMP_W below 16 cannot hold the clamp limits");
    end

    logic signed [TEMP_W:0] temp_ext;
    logic signed [TEMP_W:0] sum;
    logic signed [TEMP_W:0] steps;
    logic        [7:0]      index_nxt;

    always_comb
    begin
        temp_ext = {calc_if.temp[TEMP_W-1], calc_if.temp};
        sum      = temp_ext + OFFSET_RAW;
        steps    = sum >>> fel_pkg::INDEX_SHIFT;
        if (temp_ext < -OFFSET_RAW)
            index_nxt = fel_pkg::INDEX_BASE;
        else if (temp_ext > HIGH_RAW)
            index_nxt = fel_pkg::INDEX_MAX;
        else
            index_nxt = 8'(fel_pkg::INDEX_BASE + {1'b0, steps[6:0]});
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            calc_if.index <= 8'h00;
            calc_if.upd   <= 1'b0;
        end
        else
        begin
            calc_if.upd <= calc_if.done;
            if (calc_if.done)
                calc_if.index <= index_nxt;
        end
    end

    a_index_zero_deg: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        calc_if.done && calc_if.temp == '0 |=> calc_if.upd &&
        calc_if.index == 8'(fel_pkg::INDEX_BASE + fel_pkg::TEMP_OFFSET_C / fel_pkg::INDEX_STEP_C))
        else $error("index for zero degrees is wrong");

    a_index_clamped: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        calc_if.done |=> calc_if.index >= fel_pkg::INDEX_BASE &&
        calc_if.index <= fel_pkg::INDEX_MAX)
        else $error("index left the clamp range");

endmodule : fel_thermal_lut_index_calc

// *** logic/fel_regs.sv ***
`timescale 1ns/100ps
module fel_regs #(
    parameter int TEMP_W = 16
) (
    // Clock and reset
    input  wire logic              core_clk_in,
    input  wire logic              sys_rst_in,
    // Register access from the bus controller
    input  wire logic              acc_rd_in,
    input  wire logic              acc_wr_in,
    input  wire logic              acc_rx2_in,
    input  wire logic [7:0]        table_selector_in,
    input  wire logic [7:0]        acc_addr_in,
    input  wire logic [7:0]        acc_wdata_in,
    input  wire logic              i2c_stop_in,
    output logic                   acc_ack_out,
    output logic                   acc_refused_out,
    output logic      [7:0]        acc_rdata_out,
    // Access rights and row placement
    input  wire logic              level_one_password_in,
    input  wire logic              level_two_password_in,
    input  wire logic              table1_enable_row_rw_perm_in,
    input  wire logic              table1_enable_row_read_perm_in,
    input  wire logic              table2_rw_perm_in,
    input  wire logic              table2_read_perm_in,
    input  wire logic              enable_row_relocate_in,
    // Alarm and warning flags, one bit per receiver
    input  wire logic [1:0]        signal_loss_high_alarm_in,
    input  wire logic [1:0]        signal_loss_low_alarm_in,
    input  wire logic [1:0]        temperature_above_warning_in,
    input  wire logic [1:0]        temperature_below_warning_in,
    input  wire logic [1:0]        supply_above_warning_in,
    input  wire logic [1:0]        supply_below_warning_in,
    output logic                   fault_interrupt_out,
    // Shadow EEPROM
    output logic                   ee_program_out,
    // Temperature and lookup tables
    input  wire logic signed [TEMP_W-1:0] temperature_in,
    input  wire logic              temp_done_in,
    output logic                   lut_recall_out,
    output logic      [7:0]        lut_addr_out,
    output logic      [7:0]        lut8_addr_out,
    // Converter value control
    input  wire logic [1:0]        conv_value_wr_in,
    output logic      [1:0]        conv_auto_out,
    output logic      [1:0]        conv_apply_out
);
    if (TEMP_W < 16) begin : g_bad_width
        $error("fel_regs: TEMP_W below 16 is not supported");
    end

    function automatic fel_pkg::fel_decode_s decode(
        input logic [7:0] tbl,
        input logic [7:0] addr,
        input logic       rx2,
        input logic       reloc
    );
        fel_pkg::fel_decode_s d;
        logic                 row_here;
        d.kind = fel_pkg::TGT_NONE;
        d.idx  = 3'b000;
        d.tbl2 = 1'b0;
        // Row present in one table only
        row_here = (tbl == fel_pkg::TBL_ENABLE_HOME && !reloc) ||
                   (tbl == fel_pkg::TBL_ENABLE_ALT && reloc);
        if (row_here && addr == fel_pkg::ADDR_LOS_EN)
        begin
            d.kind = fel_pkg::TGT_REG;
            d.idx  = rx2 ? 3'(fel_pkg::REG_LOS2) : 3'(fel_pkg::REG_LOS1);
        end
        else if (row_here && addr == fel_pkg::ADDR_WARN_EN)
        begin
            d.kind = fel_pkg::TGT_REG;
            d.idx  = 3'(fel_pkg::REG_WARN);
        end
        else if (row_here && (addr == fel_pkg::ADDR_RSVD_FA || addr >= fel_pkg::ADDR_RSVD_ROW))
            d.kind = fel_pkg::TGT_RSVD;
        else if (tbl == fel_pkg::TBL_CONTROL)
        begin
            d.tbl2 = 1'b1;
            if (addr == fel_pkg::ADDR_MODE || addr == fel_pkg::ADDR_THERMAL_LUT_INDEX)
            begin
                d.kind = fel_pkg::TGT_REG;
                d.idx  = (addr == fel_pkg::ADDR_MODE) ? 3'(fel_pkg::REG_MODE)
                                                      : 3'(fel_pkg::REG_TIDX);
            end
            else if (addr >= fel_pkg::ADDR_RSVD2_LO && addr <= fel_pkg::ADDR_RSVD2_HI)
                d.kind = fel_pkg::TGT_RSVD;
        end
        return d;
    endfunction : decode

    function automatic logic allowed(
        input logic is_wr,
        input logic tbl2,
        input logic pw1,
        input logic pw2,
        input logic rw1,
        input logic rd1,
        input logic rw2,
        input logic rd2
    );
        logic rw;
        logic rd;
        rw = tbl2 ? rw2 : rw1;
        rd = tbl2 ? rd2 : rd1;
        return pw2 || (pw1 && (rw || (!is_wr && rd)));
    endfunction : allowed

    function automatic logic [7:0] lut8_map(input logic [7:0] idx);
        logic [7:0] byte_sel;
        byte_sel = fel_pkg::LUT8_BASE;
        if (idx[7:6] == 2'b11)
            byte_sel = fel_pkg::LUT8_TOP;
        else if (idx[7] && idx[5:4] != 2'b00)
            byte_sel = 8'(fel_pkg::LUT8_BASE + {5'b00000, idx[5:3]} - 8'h01);
        return byte_sel;
    endfunction : lut8_map

    logic                 [7:0] cfg_r       [fel_pkg::NUM_REGS];
    logic                 [7:0] pend_data_r [fel_pkg::NUM_REGS];
    logic [fel_pkg::NUM_REGS-1:0] pend_r;
    logic                 [1:0] conv_pend_r;
    logic                 [7:0] mode_w;
    logic                 [7:0] idx_use;
    logic                       acc_any;
    logic                       acc_ok;
    logic                       term_any;
    fel_pkg::fel_decode_s       dec;

    fel_calc_if #(.TEMP_W(TEMP_W)) calc_if ();

    assign calc_if.temp = temperature_in;
    assign calc_if.done = temp_done_in;
    assign mode_w       = cfg_r[fel_pkg::REG_MODE];
    assign acc_any      = acc_rd_in || acc_wr_in;

    fel_thermal_lut_index_calc #(.TEMP_W(TEMP_W)) u_calc (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .calc_if     (calc_if.calc)
    );

    always_comb
    begin
        dec    = decode(table_selector_in, acc_addr_in, acc_rx2_in, enable_row_relocate_in);
        acc_ok = dec.kind == fel_pkg::TGT_REG &&
                 allowed(acc_wr_in, dec.tbl2, level_one_password_in, level_two_password_in,
                         table1_enable_row_rw_perm_in, table1_enable_row_read_perm_in,
                         table2_rw_perm_in, table2_read_perm_in) &&
                 !(acc_wr_in && dec.idx == 3'(fel_pkg::REG_TIDX) &&
                   mode_w[fel_pkg::BIT_AUTO_INDEX]);
    end

    // Access answer, one cycle after the request
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            acc_ack_out     <= 1'b0;
            acc_refused_out <= 1'b0;
            acc_rdata_out   <= 8'h00;
        end
        else
        begin
            acc_ack_out     <= acc_any && dec.kind != fel_pkg::TGT_NONE;
            acc_refused_out <= acc_any && dec.kind != fel_pkg::TGT_NONE && !acc_ok;
            if (acc_rd_in && acc_ok)
                acc_rdata_out <= cfg_r[dec.idx];
            else if (acc_rd_in)
                acc_rdata_out <= fel_pkg::RSVD_READ_VAL;
        end
    end

    // Writes wait for STOP, then land in the register
    for (genvar i = 0; i < fel_pkg::NUM_REGS; i++)
    begin : g_reg
        always_ff @(posedge core_clk_in or posedge sys_rst_in)
        begin
            if (sys_rst_in)
            begin
                pend_r[i]      <= 1'b0;
                pend_data_r[i] <= 8'h00;
            end
            else if (acc_wr_in && acc_ok && dec.idx == 3'(i))
            begin
                pend_r[i]      <= 1'b1;
                pend_data_r[i] <= acc_wdata_in;
            end
            else if (i2c_stop_in)
                pend_r[i] <= 1'b0;
        end

        always_ff @(posedge core_clk_in or posedge sys_rst_in)
        begin
            if (sys_rst_in)
                cfg_r[i] <= fel_pkg::RST_VAL[i];
            else if (i2c_stop_in && pend_r[i])
                cfg_r[i] <= (pend_data_r[i] & fel_pkg::WR_MASK[i]) |
                            (cfg_r[i] & ~fel_pkg::WR_MASK[i]);
            else if (i == fel_pkg::REG_TIDX && calc_if.upd &&
                     mode_w[fel_pkg::BIT_AUTO_INDEX])
                cfg_r[i] <= calc_if.index;
        end
    end

    // Shadowed bytes program the EEPROM unless blocked
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            ee_program_out <= 1'b0;
        else
            ee_program_out <= i2c_stop_in && !mode_w[fel_pkg::BIT_SEE_BLOCK] &&
                              (pend_r[fel_pkg::REG_LOS1] || pend_r[fel_pkg::REG_LOS2] ||
                               pend_r[fel_pkg::REG_WARN]);
    end

    // Manual converter values, applied at STOP
    for (genvar j = 0; j < 2; j++)
    begin : g_conv
        logic manual;
        assign manual = !mode_w[fel_pkg::CONV_AUTO_BIT[j]];

        always_ff @(posedge core_clk_in or posedge sys_rst_in)
        begin
            if (sys_rst_in)
            begin
                conv_pend_r[j]    <= 1'b0;
                conv_apply_out[j] <= 1'b0;
                conv_auto_out[j]  <= 1'b1;
            end
            else
            begin
                conv_auto_out[j]  <= !manual;
                // Apply only at the STOP condition
                conv_apply_out[j] <= i2c_stop_in &&
                                     (conv_pend_r[j] || (conv_value_wr_in[j] && manual));
                if (i2c_stop_in)
                    conv_pend_r[j] <= 1'b0;
                else if (conv_value_wr_in[j] && manual)
                    conv_pend_r[j] <= 1'b1;
            end
        end
    end

    // Recall on each finished conversion, using the current index
    assign idx_use = mode_w[fel_pkg::BIT_AUTO_INDEX] ? calc_if.index
                                                     : cfg_r[fel_pkg::REG_TIDX];

    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            lut_recall_out <= 1'b0;
            lut_addr_out   <= 8'h00;
            lut8_addr_out  <= 8'h00;
        end
        else
        begin
            lut_recall_out <= calc_if.upd;
            if (calc_if.upd)
            begin
                lut_addr_out  <= {fel_pkg::LUT_ROW_FIXED, idx_use[6:0]};
                lut8_addr_out <= lut8_map(idx_use);
            end
        end
    end

    always_comb
    begin
        term_any =
            |(signal_loss_high_alarm_in &
              {cfg_r[fel_pkg::REG_LOS2][fel_pkg::BIT_SIGNAL_LOSS_HIGH_ALARM],
               cfg_r[fel_pkg::REG_LOS1][fel_pkg::BIT_SIGNAL_LOSS_HIGH_ALARM]}) ||
            |(signal_loss_low_alarm_in &
              {cfg_r[fel_pkg::REG_LOS2][fel_pkg::BIT_SIGNAL_LOSS_LOW_ALARM],
               cfg_r[fel_pkg::REG_LOS1][fel_pkg::BIT_SIGNAL_LOSS_LOW_ALARM]}) ||
            (|temperature_above_warning_in && cfg_r[fel_pkg::REG_WARN][fel_pkg::BIT_TEMPERATURE_ABOVE_WARNING]) ||
            (|temperature_below_warning_in && cfg_r[fel_pkg::REG_WARN][fel_pkg::BIT_TEMPERATURE_BELOW_WARNING]) ||
            (|supply_above_warning_in && cfg_r[fel_pkg::REG_WARN][fel_pkg::BIT_SUPPLY_ABOVE_WARNING]) ||
            (|supply_below_warning_in && cfg_r[fel_pkg::REG_WARN][fel_pkg::BIT_SUPPLY_BELOW_WARNING]);
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            fault_interrupt_out <= 1'b0;
        else
            fault_interrupt_out <= term_any;
    end

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    a_los_high_gate: assert property (
        signal_loss_high_alarm_in[0] && cfg_r[fel_pkg::REG_LOS1][fel_pkg::BIT_SIGNAL_LOSS_HIGH_ALARM]
        |=> fault_interrupt_out)
        else $error("enabled loss-high alarm did not raise fault");

    a_los_low_rx2: assert property (
        signal_loss_low_alarm_in == 2'b10 && cfg_r[fel_pkg::REG_LOS2][fel_pkg::BIT_SIGNAL_LOSS_LOW_ALARM]
        |=> fault_interrupt_out)
        else $error("receiver two loss-low alarm ignored");

    a_fault_quiet: assert property (
        !term_any ##1 !term_any |-> !fault_interrupt_out)
        else $error("fault raised without an enabled term");

    a_hidden_row: assert property (
        acc_rd_in && enable_row_relocate_in && table_selector_in == fel_pkg::TBL_ENABLE_HOME &&
        acc_addr_in == fel_pkg::ADDR_WARN_EN |=> !acc_ack_out)
        else $error("relocated row answered in home table");

    a_row_no_rights: assert property (
        acc_any && dec.kind == fel_pkg::TGT_REG && !dec.tbl2 && !level_two_password_in &&
        !level_one_password_in |=> acc_ack_out && acc_refused_out)
        else $error("enable row access without password not refused");

    a_rsvd_reads_zero: assert property (
        acc_rd_in && dec.kind == fel_pkg::TGT_RSVD |=> acc_refused_out && acc_rdata_out == 8'h00)
        else $error("reserved byte not refused");

    a_index_locked: assert property (
        acc_wr_in && dec.idx == 3'(fel_pkg::REG_TIDX) && dec.kind == fel_pkg::TGT_REG &&
        mode_w[fel_pkg::BIT_AUTO_INDEX] |=> acc_refused_out)
        else $error("index write accepted while auto indexing");

    a_apply_at_stop: assert property (
        $rose(conv_apply_out[0]) |-> $past(i2c_stop_in))
        else $error("converter value applied outside STOP");

    a_write_at_stop: assert property (
        ee_program_out |-> $past(i2c_stop_in) && !$past(mode_w[fel_pkg::BIT_SEE_BLOCK]))
        else $error("EEPROM cycle while blocked or outside STOP");

    a_lut_row: assert property (
        lut_recall_out |-> lut_addr_out[7] == fel_pkg::LUT_ROW_FIXED &&
        lut8_addr_out >= fel_pkg::LUT8_BASE)
        else $error("table address out of row");

    c_refused_write: cover property (acc_wr_in ##1 acc_refused_out);
    c_manual_apply: cover property (conv_value_wr_in[1] ##[1:20] conv_apply_out[1]);
    c_fault: cover property ($rose(fault_interrupt_out));
    c_recall: cover property (lut_recall_out && lut8_addr_out == fel_pkg::LUT8_TOP);

endmodule : fel_regs

// *** bench/fel_host_model.sv ***
`timescale 1ns/100ps
module fel_host_model (
    // Clock
    input  wire logic       clk_in,
    // Request
    output logic            rd_out,
    output logic            wr_out,
    output logic            stop_out,
    output logic      [7:0] tbl_out,
    output logic      [7:0] addr_out,
    output logic      [7:0] wdata_out,
    // Answer
    input  wire logic       ack_in,
    input  wire logic       ref_in,
    input  wire logic [7:0] rdata_in
);
    initial {rd_out, wr_out, stop_out, tbl_out, addr_out, wdata_out} = '0;
    // Code is {ack, refused}; 00 when nothing answers
    task automatic acc(input logic w, input logic [7:0] t, a, d,
                       output logic [1:0] ar, output logic [7:0] q);
        @(posedge clk_in);
        rd_out <= !w;
        wr_out <= w;
        tbl_out <= t;
        addr_out <= a;
        wdata_out <= d;
        @(posedge clk_in);
        rd_out <= 1'b0;
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
        ar = 2'b00;
        q = 8'h00;
        repeat (3)
        begin
            #1;
            if (ack_in === 1'b1 && ar == 2'b00)
            begin
                ar = {1'b1, ref_in};
                q = rdata_in;
            end
            @(posedge clk_in);
        end
    endtask : acc
    task automatic stop();
        @(posedge clk_in);
        stop_out <= 1'b1;
        @(posedge clk_in);
        stop_out <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask : stop
endmodule : fel_host_model

// *** bench/testbench.sv ***
`timescale 1ns/100ps
module testbench;
    logic core_clk_in, sys_rst_in, acc_rd_in, acc_wr_in, acc_rx2_in, i2c_stop_in;
    logic [7:0] table_selector_in, acc_addr_in, acc_wdata_in, acc_rdata_out, q;
    logic acc_ack_out, acc_refused_out, fault_interrupt_out, ee_program_out;
    logic level_one_password_in, level_two_password_in, table1_enable_row_rw_perm_in;
    logic table1_enable_row_read_perm_in, table2_rw_perm_in, table2_read_perm_in;
    logic enable_row_relocate_in, temp_done_in, lut_recall_out;
    logic [11:0] alm;
    logic signed [15:0] temperature_in;
    logic [7:0] lut_addr_out, lut8_addr_out;
    logic [1:0] conv_value_wr_in, conv_auto_out, conv_apply_out, ar;
    int fail_count, n_compared, ee_cnt, app_cnt, i;
    fel_regs #(.TEMP_W(16)) u_dut (.core_clk_in, .sys_rst_in, .acc_rd_in, .acc_wr_in,
        .acc_rx2_in, .table_selector_in, .acc_addr_in, .acc_wdata_in, .i2c_stop_in,
        .acc_ack_out, .acc_refused_out, .acc_rdata_out, .level_one_password_in,
        .level_two_password_in, .table1_enable_row_rw_perm_in,
        .table1_enable_row_read_perm_in, .table2_rw_perm_in,
        .table2_read_perm_in, .enable_row_relocate_in,
        .signal_loss_high_alarm_in(alm[1:0]), .signal_loss_low_alarm_in(alm[3:2]),
        .temperature_above_warning_in(alm[5:4]), .temperature_below_warning_in(alm[7:6]),
        .supply_above_warning_in(alm[9:8]), .supply_below_warning_in(alm[11:10]),
        .fault_interrupt_out, .ee_program_out, .temperature_in, .temp_done_in,
        .lut_recall_out, .lut_addr_out, .lut8_addr_out, .conv_value_wr_in,
        .conv_auto_out, .conv_apply_out);
    fel_host_model u_host (.clk_in(core_clk_in), .rd_out(acc_rd_in), .wr_out(acc_wr_in),
        .stop_out(i2c_stop_in), .tbl_out(table_selector_in), .addr_out(acc_addr_in),
        .wdata_out(acc_wdata_in), .ack_in(acc_ack_out), .ref_in(acc_refused_out),
        .rdata_in(acc_rdata_out));
    initial
    begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    always @(negedge core_clk_in) if (ee_program_out === 1'b1) ee_cnt++;
    always @(negedge core_clk_in) if (conv_apply_out === 2'b11) app_cnt++;
    task automatic chk(input logic [7:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic io(input logic w, input logic [7:0] t, a, d, ear, eq);
        u_host.acc(w, t, a, d, ar, q);
        chk({6'h00, ar}, ear);
        if (!w) chk(q, eq);
    endtask : io
    task automatic tcase(input logic [15:0] t, input logic [7:0] ei, e8);
        logic f;
        f = 1'b0;
        @(posedge core_clk_in);
        temperature_in <= t;
        temp_done_in <= 1'b1;
        @(posedge core_clk_in);
        temp_done_in <= 1'b0;
        repeat (4)
        begin
            #1;
            if (lut_recall_out === 1'b1 && !f)
            begin
                f = 1'b1;
                chk(lut_addr_out, ei);
                chk(lut8_addr_out, e8);
            end
            @(posedge core_clk_in);
        end
        chk({7'h00, f}, 8'h01);
    endtask : tcase
    task automatic flt(input logic [11:0] v, input logic e);
        alm <= v;
        repeat (3) @(posedge core_clk_in);
        chk({7'h00, fault_interrupt_out}, {7'h00, e});
    endtask : flt
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    initial
    begin
        {sys_rst_in, acc_rx2_in, level_one_password_in, table1_enable_row_rw_perm_in} = 4'h8;
        {level_two_password_in, enable_row_relocate_in, temp_done_in} = 3'h1 << 2;
        {alm, temperature_in, conv_value_wr_in} = '0;
        {table1_enable_row_read_perm_in, table2_rw_perm_in, table2_read_perm_in} = 3'h0;
        repeat (5) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        io(0, 8'h02, 8'h80, 8'h00, 8'h02, 8'h7F);
        io(0, 8'h02, 8'h81, 8'h00, 8'h02, 8'h00);
        io(1, 8'h02, 8'h81, 8'h55, 8'h03, 8'h00);
        tcase(16'h1900, 8'hA0, 8'hFB);
        tcase(16'h0000, 8'h94, 8'hF9);
        tcase(16'hCE00, 8'h80, 8'hF8);
        tcase(16'h6600, 8'hC7, 8'hFF);
        tcase(16'h7000, 8'hC7, 8'hFF);
        tcase(16'hEC00, 8'h8A, 8'hF8);
        $display("test temperature index finished");
        io(0, 8'h01, 8'hFB, 8'h00, 8'h02, 8'h00);
        io(1, 8'h01, 8'hFB, 8'hFF, 8'h02, 8'h00);
        acc_rx2_in <= 1'b1;
        io(1, 8'h01, 8'hFB, 8'h40, 8'h02, 8'h00);
        acc_rx2_in <= 1'b0;
        u_host.stop();
        chk(ee_cnt[7:0], 8'h01);
        io(0, 8'h01, 8'hFB, 8'h00, 8'h02, 8'hC0);
        acc_rx2_in <= 1'b1;
        io(0, 8'h01, 8'hFB, 8'h00, 8'h02, 8'h40);
        acc_rx2_in <= 1'b0;
        flt(12'h001, 1'b1);
        flt(12'h002, 1'b0);
        flt(12'h008, 1'b1);
        flt(12'h004, 1'b1);
        flt(12'h010, 1'b0);
        $display("test loss enables finished");
        io(1, 8'h02, 8'h80, 8'h80, 8'h02, 8'h00);
        u_host.stop();
        io(0, 8'h02, 8'h80, 8'h00, 8'h02, 8'hB3);
        chk({6'h00, conv_auto_out}, 8'h00);
        conv_value_wr_in <= 2'b11;
        @(posedge core_clk_in);
        conv_value_wr_in <= 2'b00;
        repeat (3) @(posedge core_clk_in);
        chk(app_cnt[7:0], 8'h00);
        io(1, 8'h01, 8'hFC, 8'hF0, 8'h02, 8'h00);
        u_host.stop();
        chk(app_cnt[7:0], 8'h01);
        chk(ee_cnt[7:0], 8'h01);
        flt(12'h020, 1'b1);
        io(1, 8'h02, 8'h80, 8'h00, 8'h02, 8'h00);
        u_host.stop();
        io(1, 8'h01, 8'hFC, 8'hF0, 8'h02, 8'h00);
        u_host.stop();
        chk(ee_cnt[7:0], 8'h02);
        io(1, 8'h02, 8'h81, 8'h95, 8'h02, 8'h00);
        u_host.stop();
        io(0, 8'h02, 8'h81, 8'h00, 8'h02, 8'h95);
        tcase(16'h1900, 8'h95, 8'hF9);
        $display("test mode finished");
        io(0, 8'h01, 8'hFA, 8'h00, 8'h03, 8'h00);
        io(0, 8'h02, 8'h83, 8'h00, 8'h03, 8'h00);
        {level_two_password_in, level_one_password_in} <= 2'b01;
        io(0, 8'h01, 8'hFB, 8'h00, 8'h03, 8'h00);
        io(0, 8'h02, 8'h80, 8'h00, 8'h03, 8'h00);
        {table1_enable_row_read_perm_in, table2_read_perm_in} <= 2'b11;
        io(0, 8'h01, 8'hFB, 8'h00, 8'h02, 8'hC0);
        io(1, 8'h01, 8'hFB, 8'h00, 8'h03, 8'h00);
        io(0, 8'h02, 8'h81, 8'h00, 8'h02, 8'h95);
        io(0, 8'h02, 8'h80, 8'h00, 8'h02, 8'h33);
        io(1, 8'h02, 8'h80, 8'h33, 8'h03, 8'h00);
        table2_rw_perm_in <= 1'b1;
        io(1, 8'h02, 8'h80, 8'h33, 8'h02, 8'h00);
        table1_enable_row_rw_perm_in <= 1'b1;
        io(0, 8'h01, 8'hFB, 8'h00, 8'h02, 8'hC0);
        level_one_password_in <= 1'b0;
        io(1, 8'h01, 8'hFB, 8'h00, 8'h03, 8'h00);
        {level_two_password_in, enable_row_relocate_in} <= 2'b11;
        io(0, 8'h01, 8'hFC, 8'h00, 8'h00, 8'h00);
        io(0, 8'h05, 8'hFB, 8'h00, 8'h02, 8'hC0);
        $display("test access finished");
        results();
    end
endmodule : testbench
